// ---- core/mcp_pkg.sv ----
/*
  Constants and carrier types for the macrocell power-up and preload block.
  Assumes a single 20 MHz system clock and a synchronous active-low reset.
*/
// Operation
// R1: Registers clear automatically at power-up within 1000 ns.
// R2: Every macrocell flip-flop holds LOW after power-up.
// R3: Registered pins show HIGH after power-up, whatever the polarity.
// R4: Outside party raises no register clock before setups are met.
// R5: Tester disables outputs, drives registered pins, floats combinatorial ones.
// R6: Tester pulses the load strobe low then high to load pin levels.
// R7: Tester releases pins, re-enables outputs, then checks levels.
// R8: Preload path inverted like output path; pin level reappears after load.
// R9: Unconnected inputs and pins read HIGH through weak pull-ups.
// R10: Output drives only when global enable low and local term high.
// R11: Load strobe affects only registered macrocells.
package mcp_pkg;

  localparam int unsigned MCP_CELLS = 10;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned MCP_CLK_PERIOD_NS      = 50;
  localparam int unsigned MCP_POWERUP_CLEAR_TIME = 1000;  // ns, longest
  localparam int unsigned MCP_CLEAR_CYCLES =
    (MCP_POWERUP_CLEAR_TIME / MCP_CLK_PERIOD_NS) > 0 ?
    (MCP_POWERUP_CLEAR_TIME / MCP_CLK_PERIOD_NS) : 1;
  localparam int unsigned MCP_CNT_W = $clog2(MCP_CLEAR_CYCLES + 1);

  localparam logic [MCP_CELLS-1:0] MCP_ALL_LOW  = '0;
  localparam logic [MCP_CELLS-1:0] MCP_ALL_HIGH = '1;

  typedef enum logic [1:0] {
    MCP_ST_CLEAR,
    MCP_ST_RUN
  } mcp_state_type;

  // Per-cell array terms, one bit per macrocell
  typedef struct packed {
    logic [MCP_CELLS-1:0] data;      // Sum-of-products D term
    logic [MCP_CELLS-1:0] clk;       // Clock product term
    logic [MCP_CELLS-1:0] preset;    // Asynchronous preset term
    logic [MCP_CELLS-1:0] reset;     // Asynchronous reset term
    logic [MCP_CELLS-1:0] local_oe;  // Local output-enable term
  } mcp_terms_type;

  // Pin-side signals for the ten I/O pins
  typedef struct packed {
    logic [MCP_CELLS-1:0] out;
    logic [MCP_CELLS-1:0] oe;
  } mcp_pins_type;

endpackage

// ---- core/mcp_cell_bank.sv ----
/*
  Bank of macrocell flip-flops with clear, preset, reset, clock-edge load
  and preload. Assumes all controls are already synchronous to clk_sys_i.
*/
`timescale 1ns/1ps
module mcp_cell_bank
  import mcp_pkg::*;
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 clear_i,
  input  wire logic [MCP_CELLS-1:0] load_i,
  input  wire logic [MCP_CELLS-1:0] load_val_i,
  input  wire logic [MCP_CELLS-1:0] set_i,
  input  wire logic [MCP_CELLS-1:0] rst_i,
  input  wire logic [MCP_CELLS-1:0] edge_i,
  input  wire logic [MCP_CELLS-1:0] data_i,
  output logic      [MCP_CELLS-1:0] q_o
);

  logic [MCP_CELLS-1:0] q;
  logic [MCP_CELLS-1:0] next_q;

  // ****************************************************************
  // Next state, preload wins over array terms during test
  // ****************************************************************
  always_comb begin
    next_q = q;
    for (int i = 0; i < MCP_CELLS; i++) begin
      if (load_i[i]) begin
        next_q[i] = load_val_i[i];
      end else if (rst_i[i]) begin
        next_q[i] = 1'b0;
      end else if (set_i[i]) begin
        next_q[i] = 1'b1;
      end else if (edge_i[i]) begin
        next_q[i] = data_i[i];
      end
    end
    if (clear_i) begin
      next_q = MCP_ALL_LOW;  // see R2
    end
  end

  always_ff @(posedge clk_sys_i) begin
    q <= next_q;
  end

  assign q_o = q;

endmodule // mcp_cell_bank

// ---- core/mcp_macrocells.sv ----
/*
  Ten output macrocells: power-up clear, preload from pins, polarity on combinatorial cells
  and three-state control. Assumes pins and strobes come from outside the
  clock domain; the configuration straps are static.
*/
`timescale 1ns/1ps
module mcp_macrocells
  import mcp_pkg::*;
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 register_load_strobe_n_i,
  input  wire logic                 output_enable_n_i,
  input  wire logic [MCP_CELLS-1:0] pin_in_i,
  input  wire logic [MCP_CELLS-1:0] pin_connected_i,
  input  wire logic [MCP_CELLS-1:0] active_high_i,
  input  wire mcp_terms_type        terms_i,
  output logic      [MCP_CELLS-1:0] pin_out_o,
  output logic      [MCP_CELLS-1:0] pin_oe_o,
  output logic      [MCP_CELLS-1:0] pin_level_o,
  output logic                      clear_done_o
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [MCP_CELLS-1:0] pin_s1, pin_s2, con_s1, con_s2;
  logic                 pl_s1, pl_s2, pl_s3, oe_s1, oe_s2;
  mcp_terms_type        trm_s1, trm_s2;
  logic [MCP_CELLS-1:0] pol_s1, pol_s2;
  logic [MCP_CELLS-1:0] clk_d;

  always_ff @(posedge clk_sys_i) begin
    pin_s1 <= pin_in_i;
    pin_s2 <= pin_s1;
    con_s1 <= pin_connected_i;
    con_s2 <= con_s1;
    pol_s1 <= active_high_i;
    pol_s2 <= pol_s1;
    pl_s1  <= register_load_strobe_n_i;
    pl_s2  <= pl_s1;
    pl_s3  <= pl_s2;
    oe_s1  <= output_enable_n_i;
    oe_s2  <= oe_s1;
    trm_s1 <= terms_i;
    trm_s2 <= trm_s1;
    clk_d  <= trm_s2.clk;
  end

  // ****************************************************************
  // Power-up clear sequencer
  // ****************************************************************
  mcp_state_type        state, next_state;
  logic [MCP_CNT_W-1:0] cnt, next_cnt;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      MCP_ST_CLEAR: begin
        // Clear completes within the longest power-up time, see R1
        if (cnt == MCP_CNT_W'(MCP_CLEAR_CYCLES - 1)) begin
          next_state = MCP_ST_RUN;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      MCP_ST_RUN: begin
        next_cnt = cnt;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state <= MCP_ST_CLEAR;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  wire logic clearing = (state == MCP_ST_CLEAR);

  // ****************************************************************
  // Cell configuration and pin levels
  // ****************************************************************
  // Both preset and reset high bypasses the flip-flop
  wire logic [MCP_CELLS-1:0] comb_cell = trm_s2.preset & trm_s2.reset;
  wire logic [MCP_CELLS-1:0] reg_cell  = ~comb_cell;
  // Undriven pins float up; weak, so never a bus pull-up, see R9
  wire logic [MCP_CELLS-1:0] pin_lvl   = pin_s2 | ~con_s2;
  // Preload on the strobe's falling edge; setups met by tester, see R6
  wire logic pl_fall = pl_s3 & ~pl_s2;
  // Only registered cells accept the strobe, see R11
  wire logic [MCP_CELLS-1:0] load =
    {MCP_CELLS{pl_fall & ~clearing}} & reg_cell;
  // Array clock edges are ignored while clearing, see R4
  wire logic [MCP_CELLS-1:0] clk_edge =
    trm_s2.clk & ~clk_d & {MCP_CELLS{~clearing}};

  logic [MCP_CELLS-1:0] q;

  mcp_cell_bank mcp_cell_bank_i (
    .clk_sys_i  (clk_sys_i),
    .clear_i    (clearing),
    .load_i     (load),
    .load_val_i (~pin_lvl),  // Inverted preload path, see R8
    .set_i      (trm_s2.preset & reg_cell),
    .rst_i      (trm_s2.reset & reg_cell),
    .edge_i     (clk_edge),
    .data_i     (trm_s2.data),
    .q_o        (q)
  );

  // ****************************************************************
  // Output path
  // ****************************************************************
  logic [MCP_CELLS-1:0] next_out, next_oe, next_lvl;
  logic [MCP_CELLS-1:0] pin_out, pin_oe, pin_level;
  logic                 done;

  always_comb begin
    next_out = MCP_ALL_HIGH;
    next_oe  = MCP_ALL_LOW;
    for (int i = 0; i < MCP_CELLS; i++) begin
      if (reg_cell[i]) begin
        // Output inverter: register LOW gives pin HIGH, see R3 R8
        next_out[i] = ~q[i];
      end else begin
        next_out[i] = trm_s2.data[i] ~^ pol_s2[i];
      end
      // Global enable low and local term high, see R10
      next_oe[i] = ~oe_s2 & trm_s2.local_oe[i] & ~clearing;
    end
    // Pin is what we drive, else what the outside or pull-up gives
    next_lvl = (next_oe & next_out) | (~next_oe & pin_lvl);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pin_out   <= MCP_ALL_HIGH;
      pin_oe    <= MCP_ALL_LOW;
      pin_level <= MCP_ALL_HIGH;
      done      <= 1'b0;
    end else begin
      pin_out   <= next_out;
      pin_oe    <= next_oe;
      pin_level <= next_lvl;
      done      <= ~clearing;
    end
  end

  assign pin_out_o    = pin_out;
  assign pin_oe_o     = pin_oe;
  assign pin_level_o  = pin_level;
  assign clear_done_o = done;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_clear_time_bound: assert property (  // see R1
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> ##12 clearing [*8]
  ) else $error("power-up clear ended too early");

  chk_clear_ends: assert property (  // see R1
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> ##20 !clearing
  ) else $error("power-up clear overran");

  chk_done_follows: assert property (  // see R1
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !clearing |=> clear_done_o
  ) else $error("clear done flag missing after clear");

  chk_no_load_clear: assert property (  // see R2
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    clearing |-> load == MCP_ALL_LOW
  ) else $error("preload accepted during clear");

  chk_reg_out_inv: assert property (  // see R8
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_cell[0] |=> pin_out[0] == !$past(q[0])
  ) else $error("registered pin not the inverse of its flip-flop");

  chk_regs_low: assert property (  // see R2
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(clearing) |-> q == MCP_ALL_LOW
  ) else $error("flip-flops not low after clear");

  chk_pins_high: assert property (  // see R3
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(clearing) |=> (pin_out | ~reg_cell) == MCP_ALL_HIGH
  ) else $error("registered pin not high after clear");

  chk_preload_inv: assert property (  // see R8
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    load[0] |=> q[0] == !$past(pin_lvl[0])
  ) else $error("preload not inverted");

  chk_oe_gating: assert property (  // see R10
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    pin_oe[0] |-> $past(!oe_s2 && trm_s2.local_oe[0])
  ) else $error("output driven without both enables");

  chk_comb_no_load: assert property (  // see R11
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    pl_fall |-> (load & comb_cell) == MCP_ALL_LOW
  ) else $error("combinatorial cell took preload");

  chk_no_edge_clear: assert property (  // see R4
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    clearing |-> clk_edge == MCP_ALL_LOW
  ) else $error("clock edge accepted during clear");

  chk_float_high: assert property (  // see R9
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !con_s2[0] && !next_oe[0] |=> pin_level[0]
  ) else $error("floating pin not high");

endmodule // mcp_macrocells

// ---- test/mcp_tester.sv ----
/*
  Board tester model: drives the load strobe, output enable and pins.
  Assumes the bench calls its tasks just after a falling clock edge.
*/
`timescale 1ns/1ps
module mcp_tester
  import mcp_pkg::*;
(
  input  wire logic                 clk_sys_i,
  output logic                      strobe_n_o,
  output logic                      oe_n_o,
  output logic      [MCP_CELLS-1:0] pin_o,
  output logic      [MCP_CELLS-1:0] conn_o
);
  initial begin
    strobe_n_o = 1'b1;
    oe_n_o     = 1'b1;
    pin_o      = '0;
    conn_o     = '0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic set_oe(input logic b);
    oe_n_o = b;
  endtask
  // Three cycles per phase before the release covers the two-flop sync on every line; the release phase waits one
  task automatic preload(input logic [7:0] v);
    oe_n_o = 1'b1;
    idle(3);
    pin_o  = {~pin_o[9:8], v};
    conn_o = 10'h0ff;
    idle(3);
    strobe_n_o = 1'b0;
    idle(3);
    strobe_n_o = 1'b1;
    idle(3);
    // Released pins show the inverse, not a stale copy
    pin_o  = ~pin_o;
    conn_o = '0;
    idle(1);
    oe_n_o = 1'b0;
  endtask
endmodule  // mcp_tester

// ---- test/mcp_macrocells_tb.sv ----
/*
  Self-checking bench for the macrocell power-up and preload block.
  Assumes the tester model and the design package are compiled first.
*/
`timescale 1ns/1ps
module mcp_macrocells_tb
  import mcp_pkg::*;
;
  logic                 clk_sys_i;
  logic                 rst_n_i;
  logic                 strobe_n;
  logic                 oe_n;
  logic [MCP_CELLS-1:0] pin_in;
  logic [MCP_CELLS-1:0] conn;
  logic [MCP_CELLS-1:0] pin_out;
  logic [MCP_CELLS-1:0] pin_oe;
  logic [MCP_CELLS-1:0] pin_level;
  logic                 clear_done;
  mcp_terms_type        terms;
  int                   fail_count;
  int                   compares;

  mcp_tester mcp_tester_i (
    .clk_sys_i  (clk_sys_i),
    .strobe_n_o (strobe_n),
    .oe_n_o     (oe_n),
    .pin_o      (pin_in),
    .conn_o     (conn)
  );
  mcp_macrocells mcp_macrocells_i (
    .clk_sys_i                (clk_sys_i),
    .rst_n_i                  (rst_n_i),
    .register_load_strobe_n_i (strobe_n),
    .output_enable_n_i        (oe_n),
    .pin_in_i                 (pin_in),
    .pin_connected_i          (conn),
    .active_high_i            (10'h200),
    .terms_i                  (terms),
    .pin_out_o                (pin_out),
    .pin_oe_o                 (pin_oe),
    .pin_level_o              (pin_level),
    .clear_done_o             (clear_done)
  );

  always #25 clk_sys_i = ~clk_sys_i;

  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results;
    $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_powerup;
    int n;
    n = 0;
    // Outputs stay disabled so the enable check is the same on every call
    mcp_tester_i.set_oe(1'b1);
    rst_n_i = 1'b0;
    wait_cyc(12);
    chk("rst_pin_out", 10'h3ff, pin_out);
    rst_n_i = 1'b1;
    // Cells stay unclocked until the clear is over
    while (clear_done !== 1'b1 && n < 22) begin
      wait_cyc(1);
      n++;
    end
    chk("clear_done", 10'h001, {9'h0, clear_done});
    if (clear_done !== 1'b1) results();
    chk("pwr_out", {2'b10, 8'hff}, pin_out);
    chk("pwr_oe", 10'h000, pin_oe);
    $display("Test powerup done");
  endtask
  task automatic t_preload(input logic [7:0] v);
    mcp_tester_i.preload(v);
    wait_cyc(6);
    chk("pre_out", {2'b10, v}, pin_out);
    chk("pre_oe", 10'h3ff, pin_oe);
    chk("pre_level", {2'b10, v}, pin_level);
    $display("Test preload %h done", v);
  endtask
  task automatic t_oe;
    terms.local_oe = 10'h3fe;
    wait_cyc(6);
    chk("local_oe", 10'h3fe, pin_oe);
    mcp_tester_i.set_oe(1'b1);
    wait_cyc(6);
    chk("global_oe", 10'h000, pin_oe);
    chk("pullup", 10'h3ff, pin_level);
    terms.local_oe = 10'h3ff;
    mcp_tester_i.set_oe(1'b0);
    wait_cyc(6);
    $display("Test enables done");
  endtask
  task automatic t_array_clock;
    terms.data[0] = 1'b0;
    wait_cyc(1);
    terms.clk[0] = 1'b1;
    wait_cyc(7);
    chk("array_clk_lo", {2'b10, 8'h5b}, pin_out);
    terms.clk[0] = 1'b0;
    terms.data[0] = 1'b1;
    wait_cyc(4);
    terms.clk[0] = 1'b1;
    wait_cyc(7);
    chk("array_clk_hi", {2'b10, 8'h5a}, pin_out);
    terms.clk[0] = 1'b0;
    terms.data[0] = 1'b0;
    terms.preset[1] = 1'b1;
    wait_cyc(5);
    chk("preset", {2'b10, 8'h58}, pin_out);
    terms.preset[1] = 1'b0;
    terms.reset[1] = 1'b1;
    wait_cyc(5);
    chk("reset", {2'b10, 8'h5a}, pin_out);
    terms.reset[1] = 1'b0;
    $display("Test array clock done");
  endtask

  initial begin
    clk_sys_i      = 1'b0;
    rst_n_i        = 1'b0;
    fail_count     = 0;
    compares       = 0;
    terms.data     = 10'h300;
    terms.clk      = '0;
    terms.preset   = 10'h300;
    terms.reset    = 10'h300;
    terms.local_oe = 10'h3ff;
    t_powerup();
    t_preload(8'ha5);
    t_preload(8'h5a);
    t_oe();
    t_array_clock();
    // A second power-up must wipe the preloaded state
    t_powerup();
    results();
  end
endmodule  // mcp_macrocells_tb
